// File: shared/vmg_regs.svh
// Purpose: Offsets, field positions and reset values of the monitor/pin register bank
// Assumes: Byte-wide registers on an 8-bit address
// Notes: Summary list below
//
// Summary of operation
// [RULE_01] Measurement split: low byte, bits 9..8 high
// [RULE_02] Scale field bits 3..2 of upper byte
// [RULE_03] Measurement equals voltage over scale factor
// [RULE_04] Manager reads low byte before high byte
// [RULE_05] Low read latches upper bits and scale
// [RULE_06] Sink-disconnect threshold 10 bits, reset A0h
// [RULE_07] Thresholds 50 mV step, bit 0 ignored
// [RULE_08] Stop-discharge threshold 10 bits, reset 1Ch
// [RULE_09] High alarm trip 10 bits, resets zero
// [RULE_10] Low alarm trip 10 bits, resets zero
// [RULE_11] Range bit: 80 mA or 800 mA
// [RULE_12] Limit (n+1)/8 of max, only while powered
// [RULE_13] Bit 1 resets protocol layer, self-clears
// [RULE_14] Bit 0 restores all register defaults, self-clears
// [RULE_15] Pin 1 drives value when enabled, else Hi-Z
// [RULE_16] Pin 1 input buffer enable gates status
// [RULE_17] Pin 2 config bit 3 selects role-swap use
// [RULE_18] Role-swap use: pin 2 low on disconnect; code lowers it only while pin 2 output is enabled
// [RULE_19] Generic pin 2 drives value, honours input enable
// [RULE_20] Status: pin 2 bit 1, pin 1 bit 0
`ifndef VMG_REGS_SVH
`define VMG_REGS_SVH
`define VMG_A_MEAS_LO 8'h70
`define VMG_A_MEAS_HI 8'h71
`define VMG_A_SNK_LO 8'h72
`define VMG_A_SNK_HI 8'h73
`define VMG_A_STOP_LO 8'h74
`define VMG_A_STOP_HI 8'h75
`define VMG_A_AHI_LO 8'h76
`define VMG_A_AHI_HI 8'h77
`define VMG_A_ALO_LO 8'h78
`define VMG_A_ALO_HI 8'h79
`define VMG_A_OCP 8'hA0
`define VMG_A_RST 8'hA2
`define VMG_A_PIN1 8'hA4
`define VMG_A_PIN2 8'hA5
`define VMG_A_STAT 8'hA6
`define VMG_RST_SNK 10'h0A0
`define VMG_RST_STOP 10'h01C
`define VMG_RST_OCP 4'hF
`define VMG_STEP_MV 50
`define VMG_MAX_LO_MA 80
`define VMG_MAX_HI_MA 800
`define VMG_BIT_PROTO_RST 1
`define VMG_BIT_FULL_RST 0
`define VMG_BIT_ROLE_SWAP 3
`define VMG_BIT_OUT_VAL 2
`define VMG_BIT_IN_EN 1
`define VMG_BIT_OUT_EN 0
`endif

// File: shared/vmg_pkg.sv
// Purpose: Types for the monitor/pin register bank
// Assumes: Nothing beyond the register header
// Notes: All state of the bank is one packed struct
package vmg_pkg;
  typedef enum logic [1:0] {
    VMG_SCALE_ONE = 2'b00,
    VMG_SCALE_HALF = 2'b01,
    VMG_SCALE_QUARTER = 2'b10,
    VMG_SCALE_RSVD = 2'b11
  } vmg_scale_t;

  typedef struct packed {
    logic [9:0] value;
    vmg_scale_t meas_scale_sel;
  } vmg_meas_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vmg_req_t;

  typedef struct packed {
    logic [9:0] sink_disc_thresh;
    logic [9:0] stop_disc_thresh;
    logic [9:0] high_trip_value;
    logic [9:0] low_trip_value;
    logic current_limit_range;
    logic [2:0] current_limit_code;
    logic pin1_out_value;
    logic pin1_in_enable;
    logic pin1_out_enable;
    logic pin2_role_swap_use;
    logic pin2_out_value;
    logic pin2_in_enable;
    logic pin2_out_enable;
    logic [3:0] meas_hold;
    logic [7:0] rdata;
    logic protocol_reset;
  } vmg_state_t;
endpackage : vmg_pkg

// File: logic/vmg_bank.sv
// Purpose: Register bank for bus measurement, thresholds, cable current limit, resets, two pins
// Assumes: Byte-wide register port from the serial slave, synchronous inputs
// Notes: Threshold comparators and converter live elsewhere; comparators take the threshold outputs here, converter drives i_meas
`timescale 1ns/1ps
`include "vmg_regs.svh"
`default_nettype none
module vmg_bank
  import vmg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire vmg_req_t i_req,
  output logic [7:0] o_rdata,
  input wire vmg_meas_t i_meas,
  input wire logic i_cable_power_on,
  input wire logic i_vbus_disconnect,
  input wire logic i_pin1_in,
  input wire logic i_pin2_in,
  output logic o_pin1_out,
  output logic o_pin1_oe,
  output logic o_pin2_out,
  output logic o_pin2_oe,
  output logic [9:0] o_sink_disc_cmp,
  output logic [9:0] o_stop_disc_cmp,
  output logic [9:0] o_high_trip_cmp,
  output logic [9:0] o_low_trip_cmp,
  output logic [9:0] o_current_limit_ma,
  output logic o_protocol_reset
);
  vmg_state_t st;
  vmg_state_t next_st;
  logic [7:0] rd_mux;
  logic [9:0] max_ma;
  logic [13:0] lim_prod;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_mux = 8'h00;
    case (i_req.addr)
      `VMG_A_MEAS_LO: rd_mux = i_meas.value[7:0]; // RULE_01 RULE_03
      `VMG_A_MEAS_HI: rd_mux = {4'h0, st.meas_hold}; // RULE_05
      `VMG_A_SNK_LO: rd_mux = st.sink_disc_thresh[7:0];
      `VMG_A_SNK_HI: rd_mux = {6'h00, st.sink_disc_thresh[9:8]};
      `VMG_A_STOP_LO: rd_mux = st.stop_disc_thresh[7:0];
      `VMG_A_STOP_HI: rd_mux = {6'h00, st.stop_disc_thresh[9:8]};
      `VMG_A_AHI_LO: rd_mux = st.high_trip_value[7:0];
      `VMG_A_AHI_HI: rd_mux = {6'h00, st.high_trip_value[9:8]};
      `VMG_A_ALO_LO: rd_mux = st.low_trip_value[7:0];
      `VMG_A_ALO_HI: rd_mux = {6'h00, st.low_trip_value[9:8]};
      `VMG_A_OCP: rd_mux = {4'h0, st.current_limit_range, st.current_limit_code};
      `VMG_A_RST: rd_mux = 8'h00;
      `VMG_A_PIN1: rd_mux = {5'h00, st.pin1_out_value, st.pin1_in_enable, st.pin1_out_enable};
      `VMG_A_PIN2: rd_mux = {4'h0, st.pin2_role_swap_use, st.pin2_out_value,
                             st.pin2_in_enable, st.pin2_out_enable};
      // Disabled buffer reads low rather than a floating level
      `VMG_A_STAT: rd_mux = {6'h00, i_pin2_in & st.pin2_in_enable & ~st.pin2_role_swap_use,
                             i_pin1_in & st.pin1_in_enable}; // RULE_16 RULE_19 RULE_20
      default: rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.protocol_reset = 1'b0;
    if (i_req.rd) begin
      next_st.rdata = rd_mux;
      // Upper bits latched with the low byte so the pair is one sample
      if (i_req.addr == `VMG_A_MEAS_LO) begin
        next_st.meas_hold = {i_meas.meas_scale_sel, i_meas.value[9:8]}; // RULE_05 RULE_02
      end
    end
    if (i_req.wr) begin
      case (i_req.addr)
        `VMG_A_SNK_LO: next_st.sink_disc_thresh[7:0] = i_req.wdata; // RULE_06
        `VMG_A_SNK_HI: next_st.sink_disc_thresh[9:8] = i_req.wdata[1:0]; // RULE_06
        `VMG_A_STOP_LO: next_st.stop_disc_thresh[7:0] = i_req.wdata; // RULE_08
        `VMG_A_STOP_HI: next_st.stop_disc_thresh[9:8] = i_req.wdata[1:0]; // RULE_08
        `VMG_A_AHI_LO: next_st.high_trip_value[7:0] = i_req.wdata; // RULE_09
        `VMG_A_AHI_HI: next_st.high_trip_value[9:8] = i_req.wdata[1:0]; // RULE_09
        `VMG_A_ALO_LO: next_st.low_trip_value[7:0] = i_req.wdata; // RULE_10
        `VMG_A_ALO_HI: next_st.low_trip_value[9:8] = i_req.wdata[1:0]; // RULE_10
        `VMG_A_OCP: begin
          next_st.current_limit_range = i_req.wdata[3];
          next_st.current_limit_code = i_req.wdata[2:0];
        end
        `VMG_A_RST: begin
          next_st.protocol_reset = i_req.wdata[`VMG_BIT_PROTO_RST]; // RULE_13
          if (i_req.wdata[`VMG_BIT_FULL_RST]) begin
            next_st = '0; // RULE_14
            next_st.sink_disc_thresh = `VMG_RST_SNK;
            next_st.stop_disc_thresh = `VMG_RST_STOP;
            {next_st.current_limit_range, next_st.current_limit_code} = `VMG_RST_OCP;
            next_st.protocol_reset = i_req.wdata[`VMG_BIT_PROTO_RST];
          end
        end
        `VMG_A_PIN1: begin
          next_st.pin1_out_value = i_req.wdata[`VMG_BIT_OUT_VAL];
          next_st.pin1_in_enable = i_req.wdata[`VMG_BIT_IN_EN];
          next_st.pin1_out_enable = i_req.wdata[`VMG_BIT_OUT_EN];
        end
        `VMG_A_PIN2: begin
          next_st.pin2_role_swap_use = i_req.wdata[`VMG_BIT_ROLE_SWAP]; // RULE_17
          next_st.pin2_out_value = i_req.wdata[`VMG_BIT_OUT_VAL];
          next_st.pin2_in_enable = i_req.wdata[`VMG_BIT_IN_EN];
          next_st.pin2_out_enable = i_req.wdata[`VMG_BIT_OUT_EN];
        end
        default: ;
      endcase
    end
    // Hardware clear wins over a same-cycle software set
    if (st.pin2_role_swap_use && st.pin2_out_enable && i_vbus_disconnect) begin
      next_st.pin2_out_value = 1'b0; // RULE_18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.sink_disc_thresh <= `VMG_RST_SNK;
      st.stop_disc_thresh <= `VMG_RST_STOP;
      {st.current_limit_range, st.current_limit_code} <= `VMG_RST_OCP;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign max_ma = st.current_limit_range ? 10'(`VMG_MAX_HI_MA) : 10'(`VMG_MAX_LO_MA); // RULE_11
  assign lim_prod = 14'(max_ma) * 14'({1'b0, st.current_limit_code} + 4'h1);
  // Zero limit while cable power is off: limiter idle
  assign o_current_limit_ma = i_cable_power_on ? lim_prod[12:3] : 10'h000; // RULE_12
  // Bit 0 dropped: comparators see 100 mV resolution
  assign o_sink_disc_cmp = {st.sink_disc_thresh[9:1], 1'b0}; // RULE_07
  assign o_stop_disc_cmp = {st.stop_disc_thresh[9:1], 1'b0}; // RULE_07
  assign o_high_trip_cmp = {st.high_trip_value[9:1], 1'b0}; // RULE_07
  assign o_low_trip_cmp = {st.low_trip_value[9:1], 1'b0}; // RULE_07
  assign o_rdata = st.rdata;
  assign o_protocol_reset = st.protocol_reset; // RULE_13
  assign o_pin1_oe = st.pin1_out_enable; // RULE_15
  assign o_pin1_out = st.pin1_out_value; // RULE_15
  assign o_pin2_oe = st.pin2_out_enable; // RULE_19
  assign o_pin2_out = st.pin2_out_value; // RULE_18 RULE_19

  ////////////////////////////////////////////////////////////////////////////
  property p_low_read_latches;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_req.rd && !i_req.wr && i_req.addr == `VMG_A_MEAS_LO) |=>
      st.meas_hold == {$past(i_meas.meas_scale_sel), $past(i_meas.value[9:8])};
  endproperty
  a_low_read_latches: assert property (p_low_read_latches) // RULE_05
    else $error("holding register missed low-byte read");

  property p_high_read_returns_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `VMG_A_MEAS_HI) |=> o_rdata == {4'h0, $past(st.meas_hold)};
  endproperty
  a_high_read_returns_hold: assert property (p_high_read_returns_hold) // RULE_01
    else $error("upper measurement read wrong");

  sequence s_proto_req;
    i_req.wr && i_req.addr == `VMG_A_RST && i_req.wdata[`VMG_BIT_PROTO_RST];
  endsequence
  sequence s_proto_pulse;
    o_protocol_reset ##1
      (!o_protocol_reset || $past(i_req.wr && i_req.addr == `VMG_A_RST && i_req.wdata[1]));
  endsequence
  property p_proto_pulse;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_proto_req |=> s_proto_pulse;
  endproperty
  a_proto_pulse: assert property (p_proto_pulse) // RULE_13
    else $error("protocol reset not a self-clearing pulse");

  property p_full_reset;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_req.wr && i_req.addr == `VMG_A_RST && i_req.wdata[0] && !i_vbus_disconnect) |=>
      st.sink_disc_thresh == 10'h0A0 && st.stop_disc_thresh == 10'h01C &&
      st.high_trip_value == 10'h000 && !o_pin1_oe && !o_pin2_oe;
  endproperty
  a_full_reset: assert property (p_full_reset) // RULE_14
    else $error("full register reset left state");

  property p_cmp_bit0;
    @(posedge i_ref_clk) disable iff (i_rst)
    !o_sink_disc_cmp[0] && !o_stop_disc_cmp[0] && !o_high_trip_cmp[0] && !o_low_trip_cmp[0]
      && o_sink_disc_cmp[9:1] == st.sink_disc_thresh[9:1];
  endproperty
  a_cmp_bit0: assert property (p_cmp_bit0) // RULE_07
    else $error("threshold bit 0 reached comparator");

  property p_limit_value;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_cable_power_on && st.current_limit_code == 3'h7) |->
      o_current_limit_ma == (st.current_limit_range ? 10'h320 : 10'h050);
  endproperty
  a_limit_value: assert property (p_limit_value) // RULE_12
    else $error("full-scale limit wrong");

  property p_limit_off;
    @(posedge i_ref_clk) disable iff (i_rst)
    !i_cable_power_on |-> o_current_limit_ma == 10'h000;
  endproperty
  a_limit_off: assert property (p_limit_off) // RULE_12
    else $error("limit active without cable power");

  sequence s_swap_armed;
    st.pin2_role_swap_use && o_pin2_oe && i_vbus_disconnect;
  endsequence
  property p_swap_drop;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_swap_armed |=> !o_pin2_out;
  endproperty
  a_swap_drop: assert property (p_swap_drop) // RULE_18
    else $error("pin 2 not pulled low on disconnect");

  property p_status_gate;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `VMG_A_STAT && !st.pin1_in_enable && !st.pin2_in_enable)
      |=> o_rdata == 8'h00;
  endproperty
  a_status_gate: assert property (p_status_gate) // RULE_20
    else $error("status shows disabled input");

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane write paths
  sequence s_wr(logic [7:0] a);
    i_req.wr && i_req.addr == a;
  endsequence

  property p_snk_lo;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_wr(`VMG_A_SNK_LO) |=> st.sink_disc_thresh[7:0] == $past(i_req.wdata);
  endproperty
  a_snk_lo: assert property (p_snk_lo) // RULE_06
    else $error("sink threshold low byte not written");

  property p_snk_hi;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_wr(`VMG_A_SNK_HI) |=> st.sink_disc_thresh[9:8] == $past(i_req.wdata[1:0]);
  endproperty
  a_snk_hi: assert property (p_snk_hi) // RULE_06
    else $error("sink threshold high bits not written");

  property p_stop_lo;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_wr(`VMG_A_STOP_LO) |=> st.stop_disc_thresh[7:0] == $past(i_req.wdata);
  endproperty
  a_stop_lo: assert property (p_stop_lo) // RULE_08
    else $error("stop threshold low byte not written");

  property p_stop_hi;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_wr(`VMG_A_STOP_HI) |=> st.stop_disc_thresh[9:8] == $past(i_req.wdata[1:0]);
  endproperty
  a_stop_hi: assert property (p_stop_hi) // RULE_08
    else $error("stop threshold high bits not written");

  property p_ahi_lo;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_wr(`VMG_A_AHI_LO) |=> st.high_trip_value[7:0] == $past(i_req.wdata);
  endproperty
  a_ahi_lo: assert property (p_ahi_lo) // RULE_09
    else $error("high trip low byte not written");

  property p_ahi_hi;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_wr(`VMG_A_AHI_HI) |=> st.high_trip_value[9:8] == $past(i_req.wdata[1:0]);
  endproperty
  a_ahi_hi: assert property (p_ahi_hi) // RULE_09
    else $error("high trip high bits not written");

  property p_alo_lo;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_wr(`VMG_A_ALO_LO) |=> st.low_trip_value[7:0] == $past(i_req.wdata);
  endproperty
  a_alo_lo: assert property (p_alo_lo) // RULE_10
    else $error("low trip low byte not written");

  property p_alo_hi;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_wr(`VMG_A_ALO_HI) |=> st.low_trip_value[9:8] == $past(i_req.wdata[1:0]);
  endproperty
  a_alo_hi: assert property (p_alo_hi) // RULE_10
    else $error("low trip high bits not written");

  property p_meas_low;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `VMG_A_MEAS_LO) |=>
      o_rdata == $past(i_meas.value[7:0]);
  endproperty
  a_meas_low: assert property (p_meas_low) // RULE_01 RULE_03
    else $error("low measurement byte not the live converter value");

  property p_ocp_write;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_wr(`VMG_A_OCP) |=>
      {st.current_limit_range, st.current_limit_code} == $past(i_req.wdata[3:0]);
  endproperty
  a_ocp_write: assert property (p_ocp_write) // RULE_11 RULE_12
    else $error("current limit fields not written");

  property p_limit_scale;
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cable_power_on |-> o_current_limit_ma ==
      (st.current_limit_range ? 10'h064 : 10'h00A) * ({7'h00, st.current_limit_code} + 10'h001);
  endproperty
  a_limit_scale: assert property (p_limit_scale) // RULE_11 RULE_12
    else $error("current limit not the selected eighth of range");

  property p_full_reset_rest;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_req.wr && i_req.addr == `VMG_A_RST && i_req.wdata[`VMG_BIT_FULL_RST]) |=>
      st.low_trip_value == 10'h000 && st.meas_hold == 4'h0 && o_rdata == 8'h00 &&
      {st.current_limit_range, st.current_limit_code} == `VMG_RST_OCP &&
      !st.pin1_in_enable && !st.pin2_in_enable && !st.pin2_role_swap_use;
  endproperty
  a_full_reset_rest: assert property (p_full_reset_rest) // RULE_14
    else $error("full register reset missed a field");

  property p_rst_reads_zero;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `VMG_A_RST) |=> o_rdata == 8'h00;
  endproperty
  a_rst_reads_zero: assert property (p_rst_reads_zero) // RULE_13 RULE_14
    else $error("self-clearing reset register read non-zero");

  property p_proto_quiet;
    @(posedge i_ref_clk) disable iff (i_rst)
    !(i_req.wr && i_req.addr == `VMG_A_RST && i_req.wdata[`VMG_BIT_PROTO_RST]) |=>
      !o_protocol_reset;
  endproperty
  a_proto_quiet: assert property (p_proto_quiet) // RULE_13
    else $error("protocol reset pulsed without a request");

  property p_pin1_write;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_wr(`VMG_A_PIN1) |=>
      {o_pin1_out, st.pin1_in_enable, o_pin1_oe} == $past(i_req.wdata[2:0]);
  endproperty
  a_pin1_write: assert property (p_pin1_write) // RULE_15 RULE_16
    else $error("pin 1 configuration not written");

  property p_pin1_status;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `VMG_A_STAT) |=>
      o_rdata[0] == $past(i_pin1_in && st.pin1_in_enable) && o_rdata[7:2] == 6'h00;
  endproperty
  a_pin1_status: assert property (p_pin1_status) // RULE_16 RULE_20
    else $error("pin 1 status bit wrong");

  property p_pin2_status;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_req.rd && i_req.addr == `VMG_A_STAT) |=>
      o_rdata[1] == $past(i_pin2_in && st.pin2_in_enable && !st.pin2_role_swap_use);
  endproperty
  a_pin2_status: assert property (p_pin2_status) // RULE_19 RULE_20
    else $error("pin 2 status bit wrong");

  property p_swap_sel;
    @(posedge i_ref_clk) disable iff (i_rst)
    s_wr(`VMG_A_PIN2) |=> st.pin2_role_swap_use == $past(i_req.wdata[`VMG_BIT_ROLE_SWAP]);
  endproperty
  a_swap_sel: assert property (p_swap_sel) // RULE_17
    else $error("role-swap use bit not written");

  property p_pin2_generic;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_req.wr && i_req.addr == `VMG_A_PIN2 && !i_vbus_disconnect) |=>
      o_pin2_out == $past(i_req.wdata[`VMG_BIT_OUT_VAL]) &&
      o_pin2_oe == $past(i_req.wdata[`VMG_BIT_OUT_EN]);
  endproperty
  a_pin2_generic: assert property (p_pin2_generic) // RULE_19
    else $error("pin 2 drive not taken from its value and enable bits");

  // Only a write may raise pin 2; a disconnect only lowers it
  property p_pin2_no_rise;
    @(posedge i_ref_clk) disable iff (i_rst)
    !(i_req.wr && i_req.addr == `VMG_A_PIN2) |=> !$rose(o_pin2_out);
  endproperty
  a_pin2_no_rise: assert property (p_pin2_no_rise) // RULE_18
    else $error("pin 2 rose without a write");

  property p_hold_stable;
    @(posedge i_ref_clk) disable iff (i_rst)
    !(i_req.rd && i_req.addr == `VMG_A_MEAS_LO) && !(i_req.wr && i_req.addr == `VMG_A_RST)
      |=> $stable(st.meas_hold);
  endproperty
  a_hold_stable: assert property (p_hold_stable) // RULE_05
    else $error("holding register changed without a low-byte read");
endmodule : vmg_bank
`default_nettype wire

// File: dv/vmg_mgr_model.sv
// Purpose: Port manager stand-in driving the register strobe port
// Assumes: Requests change just after a rising edge, one cycle each
// Notes: Read data is taken 1 ns after the taking edge
`timescale 1ns/1ps
`default_nettype none
module vmg_mgr_model
  import vmg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [7:0] i_rdata,
  output var vmg_req_t o_req
);
  initial o_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_req <= '{1'b1, 1'b0, a, d};
    @(posedge i_ref_clk);
    o_req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [9:0] d);
    @(posedge i_ref_clk);
    o_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_ref_clk);
    o_req <= '0;
    #1;
    d = {2'h0, i_rdata};
  endtask : rd
  // Low byte first so the upper bits come from the same sample
  task automatic rd_meas(output logic [9:0] lo, output logic [9:0] hi);
    rd(8'h70, lo);
    rd(8'h71, hi);
  endtask : rd_meas
endmodule : vmg_mgr_model
`default_nettype wire

// File: dv/vmg_bank_tb_top.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Manager model issues all register traffic
// Notes: Expectations come from the register layout, not the design
`timescale 1ns/1ps
`include "vmg_regs.svh"
`default_nettype none
module vmg_bank_tb_top
  import vmg_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, pwr = 1'b1, disc = 1'b0, p1 = 1'b0, p2 = 1'b0;
  logic p1o, p1e, p2o, p2e, prst;
  logic [7:0] rdata;
  logic [9:0] snk, stp, ahi, alo, lim, v, w;
  vmg_req_t req;
  vmg_meas_t meas = '0;
  int n_errors = 0, check_count = 0;
  initial forever #4 clk = ~clk;
  vmg_mgr_model mgr (.i_ref_clk(clk), .i_rdata(rdata), .o_req(req));
  vmg_bank dut (.i_ref_clk(clk), .i_rst(rst), .i_req(req), .o_rdata(rdata), .i_meas(meas),
    .i_cable_power_on(pwr), .i_vbus_disconnect(disc), .i_pin1_in(p1), .i_pin2_in(p2),
    .o_pin1_out(p1o), .o_pin1_oe(p1e), .o_pin2_out(p2o), .o_pin2_oe(p2e),
    .o_sink_disc_cmp(snk), .o_stop_disc_cmp(stp), .o_high_trip_cmp(ahi),
    .o_low_trip_cmp(alo), .o_current_limit_ma(lim), .o_protocol_reset(prst));
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    mgr.rd(a, v);
    chk(v, {2'h0, e});
  endtask : rchk
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    logic [7:0] a[12] = '{8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79,
      8'hA0, 8'hA2, 8'hA4, 8'hA5};
    logic [7:0] e[12] = '{8'hA0, 0, 8'h1C, 0, 0, 0, 0, 0, 8'h0F, 0, 0, 0};
    for (int i = 0; i < 12; i++) rchk(a[i], e[i]);
    chk(snk, 10'h0A0);
    chk(stp, 10'h01C);
    chk(lim, 10'h320);
    rchk(8'h7A, 8'h00);
  endtask : t_reset_vals
  task automatic t_meas();
    for (int s = 0; s < 3; s++) begin
      @(posedge clk) meas <= '{10'h2A5 + 10'(s * 257), vmg_scale_t'(s)};
      mgr.rd_meas(v, w);
      chk(v, {2'h0, 8'(10'h2A5 + s * 257)});
      chk(w, {6'h0, 2'(s), 2'((10'h2A5 + s * 257) >> 8)});
    end
    @(posedge clk) meas <= '{10'h1FF, VMG_SCALE_QUARTER};
    // No new low read: last latched sample, scale 10b, bits 00b
    rchk(8'h71, 8'h08);
  endtask : t_meas
  task automatic t_thresh();
    logic [7:0] b[4] = '{8'h72, 8'h74, 8'h76, 8'h78};
    logic [9:0] x[4] = '{10'h3FF, 10'h255, 10'h133, 10'h301};
    for (int i = 0; i < 4; i++) begin
      mgr.wr(b[i], x[i][7:0]);
      mgr.wr(b[i] + 8'h01, {6'h3F, x[i][9:8]});
      rchk(b[i] + 8'h01, {6'h0, x[i][9:8]});
      rchk(b[i], x[i][7:0]);
    end
    chk(snk, 10'h3FE);
    chk(stp, 10'h254);
    chk(ahi, 10'h132);
    chk(alo, 10'h300);
  endtask : t_thresh
  task automatic t_limit();
    for (int r = 0; r < 2; r++) begin
      for (int n = 0; n < 8; n++) begin
        mgr.wr(8'hA0, {4'h0, 1'(r), 3'(n)});
        chk(lim, 10'((r ? 800 : 80) * (n + 1) / 8));
      end
    end
    @(posedge clk) pwr <= 1'b0;
    @(posedge clk) #1;
    chk(lim, 10'h000);
    @(posedge clk) pwr <= 1'b1;
  endtask : t_limit
  task automatic t_soft_reset();
    mgr.wr(8'hA2, 8'h02);
    chk(prst, 1'b1);
    @(posedge clk) #1;
    chk(prst, 1'b0);
    rchk(8'hA2, 8'h00);
    mgr.wr(8'hA4, 8'h07);
    mgr.wr(8'hA2, 8'h01);
    rchk(8'h72, 8'hA0);
    rchk(8'hA4, 8'h00);
    chk(p1e, 1'b0);
    rchk(8'hA2, 8'h00);
  endtask : t_soft_reset
  task automatic t_pins();
    @(posedge clk) p1 <= 1'b1;
    p2 <= 1'b1;
    rchk(8'hA6, 8'h00);
    mgr.wr(8'hA4, 8'h05);
    chk({p1e, p1o}, 2'b11);
    mgr.wr(8'hA4, 8'h01);
    chk({p1e, p1o}, 2'b10);
    mgr.wr(8'hA4, 8'h02);
    chk(p1e, 1'b0);
    rchk(8'hA6, 8'h01);
    mgr.wr(8'hA5, 8'h07);
    chk({p2e, p2o}, 2'b11);
    rchk(8'hA6, 8'h03);
    mgr.wr(8'hA5, 8'h0F);
    chk({p2e, p2o}, 2'b11);
    rchk(8'hA6, 8'h01);
    @(posedge clk) disc <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({p2e, p2o}, 2'b10);
    @(posedge clk) disc <= 1'b0;
  endtask : t_pins
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // Whole run is about 170 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals();
    t_meas();
    t_thresh();
    t_limit();
    t_soft_reset();
    t_pins();
    final_report();
  end
endmodule : vmg_bank_tb_top
`default_nettype wire
